// ---- eoc_ext_osc_ctrl.sv ----
// external oscillator control: mode register, pin claims, clock pick-up, valid flag, irq
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module eoc_ext_osc_ctrl
   import eoc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic osc_settled,
   input wire logic osc_sense,
   output logic osc_clk_out,
   output logic osc_input_pin_claim,
   output logic osc_output_pin_claim,
   output logic irq
);

   eoc_state_t s;
   eoc_state_t n;
   logic req;
   logic wr;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic sense_rise;
   logic [1:0] events;
   logic [7:0] ctrl_view;

   always_comb
   begin
      req = wb_cyc_i & wb_stb_i;
      // a write lands on the edge the master sees ack
      wr = req & wb_we_i & s.ack & wb_sel_i[0];
      hit_ctrl = 1'b0;
      hit_stat = 1'b0;
      hit_mask = 1'b0;
      if (wb_adr_i[11:2] == EOC_CTRL_IDX)
      begin
         hit_ctrl = 1'b1;
      end
      else if (wb_adr_i[11:2] == EOC_STAT_IDX)
      begin
         hit_stat = 1'b1;
      end
      else if (wb_adr_i[11:2] == EOC_MASK_IDX)
      begin
         hit_mask = 1'b1;
      end
      sense_rise = s.sense_sync[1] & ~s.sense_prev;
      ctrl_view = {s.valid, s.mode, 1'b0, s.freq};
   end

   always_comb
   begin
      n = s;
      n.settle_sync = {s.settle_sync[0], osc_settled};
      n.sense_sync = {s.sense_sync[0], osc_sense};
      n.sense_prev = s.sense_sync[1];

      // mode and frequency fields; bit 7 and bit 3 ignore writes
      if (wr && hit_ctrl)
      begin
         n.mode = wb_dat_i[EOC_MODE_HI:EOC_MODE_LO];
         n.freq = wb_dat_i[EOC_FREQ_HI:EOC_FREQ_LO];
      end

      // valid only while on and the amplitude detector reports settled
      n.valid = eoc_is_on(n.mode) & s.settle_sync[1];

      // pin claims follow the decoded mode
      n.in_claim = eoc_is_xtal(n.mode);
      n.out_claim = eoc_is_on(n.mode);

      // clock pick-up: follow the pin level or toggle on its rising edge
      if (!eoc_is_on(s.mode))
      begin
         n.osc_clk = 1'b0;
      end
      else if (eoc_is_div2(s.mode))
      begin
         n.osc_clk = s.osc_clk ^ sense_rise;
      end
      else
      begin
         n.osc_clk = s.sense_sync[1];
      end

      // sticky events, write one to clear, set wins over clear
      events[EOC_EV_RISE] = n.valid & ~s.valid;
      events[EOC_EV_FALL] = ~n.valid & s.valid;
      if (wr && hit_stat)
      begin
         n.status = s.status & ~wb_dat_i[1:0];
      end
      n.status = n.status | events;
      if (wr && hit_mask)
      begin
         n.mask = wb_dat_i[1:0];
      end
      n.irq = |(n.status & n.mask);

      // single-cycle answer, unmapped reads return zero
      n.ack = req & ~s.ack;
      n.rdat = 32'h0000_0000;
      if (req && !s.ack && !wb_we_i)
      begin
         if (hit_ctrl)
         begin
            n.rdat = {24'h00_0000, ctrl_view};
         end
         else if (hit_stat)
         begin
            n.rdat = {30'h0000_0000, s.status};
         end
         else if (hit_mask)
         begin
            n.rdat = {30'h0000_0000, s.mask};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.mode <= EOC_CTRL_RST[EOC_MODE_HI:EOC_MODE_LO];
         s.freq <= EOC_CTRL_RST[EOC_FREQ_HI:EOC_FREQ_LO];
         s.status <= EOC_STAT_RST;
         s.mask <= EOC_MASK_RST;
      end
      else
      begin
         s <= n;
      end
   end

   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign osc_clk_out = s.osc_clk;
   assign osc_input_pin_claim = s.in_claim;
   assign osc_output_pin_claim = s.out_claim;
   assign irq = s.irq;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_mode_write;
      (wr && hit_ctrl) |=> (s.mode == $past(wb_dat_i[EOC_MODE_HI:EOC_MODE_LO]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode field not written");

   property p_cmos_follow;
      (s.mode == EOC_MODE_CMOS) && $stable(s.mode) |=> (s.osc_clk == $past(s.sense_sync[1]));
   endproperty
   a_cmos_follow: assert property (p_cmos_follow) else $error("cmos clock not followed");

   property p_xtal_pins;
      eoc_is_xtal(s.mode) |-> (s.in_claim && s.out_claim);
   endproperty
   a_xtal_pins: assert property (p_xtal_pins) else $error("crystal pins not claimed");

   property p_one_pin;
      (eoc_is_on(s.mode) && !eoc_is_xtal(s.mode)) |-> (s.out_claim && !s.in_claim);
   endproperty
   a_one_pin: assert property (p_one_pin) else $error("wrong pins claimed");

   property p_div2;
      (eoc_is_div2(s.mode) && $stable(s.mode) && sense_rise) |=> (s.osc_clk != $past(s.osc_clk));
   endproperty
   a_div2: assert property (p_div2) else $error("divide by two did not toggle");

   property p_off;
      (!eoc_is_on(s.mode)) [*2] |-> (!s.osc_clk && !s.out_claim && !s.valid);
   endproperty
   a_off: assert property (p_off) else $error("off mode still active");

   property p_valid_rise;
      $rose(s.valid) |-> ($past(s.settle_sync[1]) && s.status[EOC_EV_RISE]);
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("valid rose without settle");

   property p_irq_level;
      ((s.status & s.mask) != 2'h0) |-> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq missing");

   property p_ack_once;
      (req && !s.ack) |=> s.ack ##1 !s.ack;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not single");

   // register bus, status, valid, irq, pin claim and clock pick-up checks
   property p_freq_write;
      (wr && hit_ctrl) |=> (s.freq == $past(wb_dat_i[EOC_FREQ_HI:EOC_FREQ_LO]));
   endproperty
   a_freq_write: assert property (p_freq_write) else $error("freq not written");

   property p_mask_write;
      (wr && hit_mask) |=> (s.mask == $past(wb_dat_i[1:0]));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask not written");

   property p_clear_status;
      (wr && hit_stat && (events == 2'h0))
         |=> ((s.status & $past(wb_dat_i[1:0])) == 2'h0);
   endproperty
   a_clear_status: assert property (p_clear_status) else $error("status not cleared");

   property p_valid_off;
      (!eoc_is_on(s.mode)) |-> !s.valid;
   endproperty
   a_valid_off: assert property (p_valid_off) else $error("valid while off");

   property p_valid_settled;
      s.valid |-> $past(s.settle_sync[1]);
   endproperty
   a_valid_settled: assert property (p_valid_settled) else $error("valid without settle");

   property p_valid_fall;
      $fell(s.valid) |-> s.status[EOC_EV_FALL];
   endproperty
   a_valid_fall: assert property (p_valid_fall) else $error("fall not recorded");

   property p_irq_low;
      ((s.status & s.mask) == 2'h0) |-> !irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("spurious irq");

   property p_claim_off;
      (!eoc_is_on(s.mode)) |-> (!s.in_claim && !s.out_claim);
   endproperty
   a_claim_off: assert property (p_claim_off) else $error("pin claimed while off");

   property p_in_claim;
      (!eoc_is_xtal(s.mode)) |-> !s.in_claim;
   endproperty
   a_in_claim: assert property (p_in_claim) else $error("input pin claimed");

   property p_follow;
      (eoc_is_on(s.mode) && !eoc_is_div2(s.mode))
         |=> (s.osc_clk == $past(s.sense_sync[1]));
   endproperty
   a_follow: assert property (p_follow) else $error("clock not followed");

   property p_div2_hold;
      (eoc_is_div2(s.mode) && $stable(s.mode) && !sense_rise)
         |=> (s.osc_clk == $past(s.osc_clk));
   endproperty
   a_div2_hold: assert property (p_div2_hold) else $error("divided clock moved");

   property p_ack_idle;
      (!req) |=> !s.ack;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

   property p_rdat_idle;
      (!s.ack) |-> (wb_dat_o == 32'h0000_0000);
   endproperty
   a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside ack");

   property p_unmapped_zero;
      (req && !s.ack && !wb_we_i && !hit_ctrl && !hit_stat && !hit_mask)
         |=> (wb_dat_o == 32'h0000_0000);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

   property p_ctrl_read;
      (req && !s.ack && !wb_we_i && hit_ctrl)
         |=> (wb_dat_o == {24'h00_0000, $past(s.valid), $past(s.mode), 1'b0, $past(s.freq)});
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

   property p_stat_read;
      (req && !s.ack && !wb_we_i && hit_stat)
         |=> (wb_dat_o == {30'h0000_0000, $past(s.status)});
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");

   property p_mask_read;
      (req && !s.ack && !wb_we_i && hit_mask)
         |=> (wb_dat_o == {30'h0000_0000, $past(s.mask)});
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

   c_xtal_valid: cover property (eoc_is_xtal(s.mode) ##[1:20] s.valid);
   c_div2_clk: cover property (eoc_is_div2(s.mode) && $rose(s.osc_clk));
   c_irq: cover property ($rose(irq));
   c_cmos_clk: cover property ((s.mode == EOC_MODE_CMOS) && $rose(s.osc_clk));
   c_valid_fall: cover property ($rose(s.status[EOC_EV_FALL]));
endmodule : eoc_ext_osc_ctrl

// ---- eoc_pkg.sv ----
// constants, field layout and state type of the external oscillator control block
package eoc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] EOC_CTRL_IDX = 10'h0B1;
   localparam logic [9:0] EOC_STAT_IDX = 10'h0B2;
   localparam logic [9:0] EOC_MASK_IDX = 10'h0B3;
   localparam logic [7:0] EOC_CTRL_RST = 8'h00;
   localparam logic [1:0] EOC_STAT_RST = 2'h0;
   localparam logic [1:0] EOC_MASK_RST = 2'h0;
   // control register field positions
   localparam int EOC_VALID_BIT = 7;
   localparam int EOC_MODE_HI = 6;
   localparam int EOC_MODE_LO = 4;
   localparam int EOC_FREQ_HI = 2;
   localparam int EOC_FREQ_LO = 0;
   // mode encodings; 00x is off
   localparam logic [2:0] EOC_MODE_CMOS = 3'h2;
   localparam logic [2:0] EOC_MODE_CMOS_DIV2 = 3'h3;
   localparam logic [2:0] EOC_MODE_RC = 3'h4;
   localparam logic [2:0] EOC_MODE_CAP = 3'h5;
   localparam logic [2:0] EOC_MODE_XTAL = 3'h6;
   localparam logic [2:0] EOC_MODE_XTAL_DIV2 = 3'h7;
   // event bits of status and mask
   localparam int EOC_EV_RISE = 0;
   localparam int EOC_EV_FALL = 1;

   typedef struct packed {
      logic [2:0] mode;
      logic [2:0] freq;
      logic valid;
      logic [1:0] settle_sync;
      logic [1:0] sense_sync;
      logic sense_prev;
      logic osc_clk;
      logic [1:0] status;
      logic [1:0] mask;
      logic irq;
      logic ack;
      logic [31:0] rdat;
      logic in_claim;
      logic out_claim;
   } eoc_state_t;

   function automatic logic eoc_is_on(input logic [2:0] m);
      return m[2] | m[1];
   endfunction : eoc_is_on

   function automatic logic eoc_is_xtal(input logic [2:0] m);
      return m[2] & m[1];
   endfunction : eoc_is_xtal

   function automatic logic eoc_is_div2(input logic [2:0] m);
      return (m == EOC_MODE_CMOS_DIV2) || (m == EOC_MODE_XTAL_DIV2);
   endfunction : eoc_is_div2
endpackage : eoc_pkg

// ---- eoc_osc_model.sv ----
// behavioural far side: oscillator network with settle delay and clock level
`timescale 1ns/10ps
module eoc_osc_model #(
   parameter int SETTLE = 8
) (
   input wire logic clock,
   input wire logic enable,
   output logic sense,
   output logic settled
);
   int cnt;
   initial
   begin
      cnt = 0;
      sense = 1'b0;
      settled = 1'b0;
   end
   // silent and unsettled while the output side is not claimed
   always @(posedge clock)
      if (!enable)
      begin
         cnt <= 0;
         sense <= 1'b0;
         settled <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 1;
         if (cnt % 4 == 3)
            sense <= ~sense;
         settled <= (cnt >= SETTLE);
      end
endmodule : eoc_osc_model

// ---- test_eoc_ext_osc_ctrl.sv ----
// self-checking testbench of the external oscillator control block
`timescale 1ns/10ps
module test_eoc_ext_osc_ctrl
   import eoc_pkg::*;
();
   localparam logic [11:0] A_CTRL = {EOC_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_STAT = {EOC_STAT_IDX, 2'b00};
   localparam logic [11:0] A_MASK = {EOC_MASK_IDX, 2'b00};
   logic clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rd, x_state = 32'hA4D0AA5B;
   logic [31:0] dat_o;
   logic ack, sense, settled, clk_out, in_claim, out_claim, irq;
   logic [2:0] hist = 3'h0;
   logic div_on = 1'b0, div_ref = 1'b0;
   int bad_count = 0, n_compared = 0, stat = 0;
   initial
   begin
      forever #50 clock = ~clock;
   end
   always @(posedge clock) hist <= {hist[1:0], sense};
   // divide-by-two reference: toggles on each synchronised rising pin edge
   always @(posedge clock) div_ref <= div_on & (div_ref ^ (hist[1] & ~hist[2]));
   eoc_ext_osc_ctrl i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .osc_settled(settled), .osc_sense(sense), .osc_clk_out(clk_out),
      .osc_input_pin_claim(in_claim), .osc_output_pin_claim(out_claim), .irq(irq));
   eoc_osc_model #(.SETTLE(8)) i_osc (.clock(clock), .enable(out_claim), .sense(sense),
      .settled(settled));
   function automatic logic [31:0] xorshift();
      x_state ^= x_state << 13;
      x_state ^= x_state >> 17;
      x_state ^= x_state << 5;
      return x_state;
   endfunction : xorshift
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1)
      begin
         bad_count++;
         complete_run();
      end
   endtask : bus
   initial
   begin
      int m;
      logic [2:0] f;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, A_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      bus(1'b0, 12'h300, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b1, A_MASK, 32'h1);
      bus(1'b0, A_MASK, 32'h0);
      chk("mask", rd, 32'h1);
      for (m = 0; m < 8; m++)
      begin
         rd = xorshift();
         f = rd[2:0];
         // written ones in read-only bits must not stick
         bus(1'b1, A_CTRL, {24'h0, 1'b1, m[2:0], 1'b1, f});
         div_on <= (m == 3) || (m == 7);
         repeat ((m >= 6) ? 10000 : 30) @(posedge clock);
         bus(1'b0, A_CTRL, 32'h0);
         chk("ctrl", rd, {24'h0, m >= 2, m[2:0], 1'b0, f});
         @(negedge clock);
         chk("input claim", in_claim, m >= 6);
         chk("output claim", out_claim, m >= 2);
         if (m >= 2)
            stat |= 1;
         bus(1'b0, A_STAT, 32'h0);
         chk("status", rd, stat);
         chk("irq", irq, stat[0]);
         repeat (12)
         begin
            @(posedge clock);
            chk("clock out", clk_out, div_on ? div_ref : (m >= 2) & hist[2]);
         end
         bus(1'b1, A_STAT, 32'h3);
         bus(1'b1, A_CTRL, 32'h0);
         div_on <= 1'b0;
         stat = (m >= 2) ? 2 : 0;
         repeat (8) @(posedge clock);
         bus(1'b0, A_STAT, 32'h0);
         chk("status after off", rd, stat);
         chk("masked irq", irq, 1'b0);
      end
      // mode 001 is off: fields stored, nothing claimed
      bus(1'b1, A_CTRL, 32'h15);
      bus(1'b0, A_CTRL, 32'h0);
      chk("ctrl off mode", rd, 32'h15);
      chk("off claims", {in_claim, out_claim}, 2'h0);
      // reset in mid-run clears the stored fields
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, A_CTRL, 32'h0);
      chk("ctrl after reset", rd, 32'h0);
      bus(1'b0, A_MASK, 32'h0);
      chk("mask after reset", rd, 32'h0);
      chk("outputs after reset", {in_claim, out_claim, irq}, 3'h0);
      complete_run();
   end
endmodule : test_eoc_ext_osc_ctrl
